// ===== rcd_core.sv
// execute stage, fetch control and status of the risc core datapath
// How it works
// (RULE1) thirty-two byte registers, single-cycle access
// (RULE2) read two operands, compute, write back
// (RULE3) next word fetched while current executes
// (RULE4) separate program and data buses
// (RULE5) three register pairs address data space
// (RULE6) z pair addresses program memory tables
// (RULE7) register, constant and single-register operations
// (RULE8) arithmetic updates the status flags
// (RULE9) short io forms reach io space only
// (RULE10) results forwarded to the next instruction
// (RULE11) pointer low byte in even register
`timescale 1ns/1ps

module rcd_core #(
  parameter int ADDR_W = rcd_pkg::ADDR_W
) (
  input  wire logic              CLOCK,
  input  wire logic              RST_B,
  output logic      [ADDR_W-1:0] PM_ADDR,
  input  wire logic [15:0]       PM_DATA,
  output logic      [ADDR_W-1:0] DM_ADDR,
  output logic      [7:0]        DM_WDATA,
  output logic                   DM_WE,
  output logic                   DM_RE,
  input  wire logic [7:0]        DM_RDATA,
  output logic      [5:0]        IO_ADDR,
  output logic      [7:0]        IO_WDATA,
  output logic                   IO_WE,
  output logic                   IO_RE,
  input  wire logic [7:0]        IO_RDATA
);
  typedef enum logic [0:0] {ST_RUN = 1'b0, ST_TABLE = 1'b1} rcd_state_t;

  rcd_state_t        state_reg;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] saved_pc_reg;
  logic [15:0]       ir_reg;
  logic [7:0]        status_reg;
  logic [4:0]        tbl_rd_reg;
  logic              tbl_hi_reg;
  logic [7:0]        rf_a;
  logic [7:0]        rf_b;
  logic [7:0]        rf_pl;
  logic [7:0]        rf_ph;
  logic [4:0]        ptr_lo_idx;
  logic [4:0]        ptr_hi_idx;
  logic [1:0]        ir_cls;
  logic [2:0]        ir_msub;
  logic [1:0]        ir_iop;
  logic [4:0]        ir_rd;
  logic [3:0]        alu_op;
  logic [7:0]        alu_b;
  logic [15:0]       alu_out;
  logic [7:0]        alu_res;
  logic [7:0]        bit_mask;
  logic [ADDR_W-1:0] z_word;
  logic [ADDR_W-1:0] target;
  logic              wb_en;
  logic [4:0]        wb_addr;
  logic [7:0]        wb_data;
  logic              sr_load;
  logic [7:0]        sr_next;
  logic              squash;
  logic              redirect;
  logic              tbl_start;

  function automatic logic [15:0] alu_calc(
    input logic [3:0] op,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [7:0] sr
  );
    logic [8:0] wide;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] r;
    logic [7:0] f;
    logic       cin;
    x = (op == rcd_pkg::ALU_NEG) ? 8'h00 : a;
    y = (op == rcd_pkg::ALU_NEG) ? a : ((op == rcd_pkg::ALU_INC || op == rcd_pkg::ALU_DEC) ? 8'h01 : b);
    cin = (op == rcd_pkg::ALU_ADC || op == rcd_pkg::ALU_SBC) ? sr[rcd_pkg::FLAG_C] : 1'b0;
    f = sr;
    wide = 9'h000;
    r = 8'h00;
    unique case (op)
      rcd_pkg::ALU_ADD, rcd_pkg::ALU_ADC, rcd_pkg::ALU_INC: begin
        wide = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        r = wide[7:0];
        // inc leaves carry and half carry alone for multi-byte loops
        if (op != rcd_pkg::ALU_INC) begin
          f[rcd_pkg::FLAG_C] = wide[8];
          f[rcd_pkg::FLAG_H] = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
        end
        f[rcd_pkg::FLAG_V] = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
      end
      rcd_pkg::ALU_SUB, rcd_pkg::ALU_SBC, rcd_pkg::ALU_CP, rcd_pkg::ALU_NEG, rcd_pkg::ALU_DEC: begin
        wide = {1'b0, x} - {1'b0, y} - {8'h00, cin};
        r = wide[7:0];
        if (op != rcd_pkg::ALU_DEC) begin
          f[rcd_pkg::FLAG_C] = wide[8];
          f[rcd_pkg::FLAG_H] = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
        end
        f[rcd_pkg::FLAG_V] = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
      end
      rcd_pkg::ALU_AND, rcd_pkg::ALU_OR, rcd_pkg::ALU_EOR, rcd_pkg::ALU_COM: begin
        r = (op == rcd_pkg::ALU_AND) ? (x & y) : (op == rcd_pkg::ALU_OR) ? (x | y) :
            (op == rcd_pkg::ALU_EOR) ? (x ^ y) : ~x;
        if (op == rcd_pkg::ALU_COM) f[rcd_pkg::FLAG_C] = 1'b1;
        f[rcd_pkg::FLAG_V] = 1'b0;
      end
      rcd_pkg::ALU_LSR, rcd_pkg::ALU_ROR: begin
        r = {(op == rcd_pkg::ALU_ROR) & sr[rcd_pkg::FLAG_C], x[7:1]};
        f[rcd_pkg::FLAG_C] = x[0];
        f[rcd_pkg::FLAG_V] = r[7] ^ x[0];
      end
      rcd_pkg::ALU_MOV: r = y;
      rcd_pkg::ALU_NOP: r = x;
    endcase
    if (op != rcd_pkg::ALU_MOV && op != rcd_pkg::ALU_NOP) begin
      f[rcd_pkg::FLAG_Z] = (r == 8'h00);
      f[rcd_pkg::FLAG_N] = r[7];
      f[rcd_pkg::FLAG_S] = r[7] ^ f[rcd_pkg::FLAG_V];
    end
    return {f, r};
  endfunction

  // --------------------------------------------------------------
  // register file, operands fetched with the instruction word
  // --------------------------------------------------------------
  // (RULE11) low byte even register
  assign ptr_lo_idx = rcd_pkg::ptr_of(PM_DATA);
  assign ptr_hi_idx = {ptr_lo_idx[4:1], 1'b1};

  rcd_regfile rcd_regfile_i (
    .clk      (CLOCK),
    .rst_n    (RST_B),
    .raddr_a  (rcd_pkg::rd_of(PM_DATA)),
    .raddr_b  (PM_DATA[4:0]),
    .raddr_pl (ptr_lo_idx),
    .raddr_ph (ptr_hi_idx),
    .rdata_a  (rf_a),
    .rdata_b  (rf_b),
    .rdata_pl (rf_pl),
    .rdata_ph (rf_ph),
    .we       (wb_en),
    .waddr    (wb_addr),
    .wdata    (wb_data)
  );

  // --------------------------------------------------------------
  // execute
  // --------------------------------------------------------------
  assign ir_cls   = ir_reg[rcd_pkg::CLS_LSB +: 2];
  assign ir_msub  = ir_reg[rcd_pkg::MSUB_LSB +: 3];
  assign ir_iop   = ir_reg[rcd_pkg::IOP_LSB +: 2];
  assign ir_rd    = rcd_pkg::rd_of(ir_reg);
  assign z_word   = ADDR_W'({rf_ph, rf_pl} >> 1);
  assign bit_mask = 8'h01 << ir_reg[2:0];

  // (RULE7) constant operations mapped onto the alu
  always_comb begin
    alu_op = ir_reg[rcd_pkg::ROP_LSB +: 4];
    alu_b  = rf_b;
    if (ir_cls == rcd_pkg::CLS_IMM) begin
      alu_b  = ir_reg[7:0];
      alu_op = (ir_iop == rcd_pkg::IMM_LDI) ? rcd_pkg::ALU_MOV : (ir_iop == rcd_pkg::IMM_SUB) ? rcd_pkg::ALU_SUB :
               (ir_iop == rcd_pkg::IMM_AND) ? rcd_pkg::ALU_AND : rcd_pkg::ALU_OR;
    end
  end

  assign alu_out = alu_calc(alu_op, rf_a, alu_b, status_reg);
  assign alu_res = alu_out[7:0];

  always_comb begin
    wb_en     = 1'b0;
    wb_addr   = ir_rd;
    wb_data   = alu_res;
    sr_load   = 1'b0;
    sr_next   = alu_out[15:8];
    DM_RE     = 1'b0;
    DM_WE     = 1'b0;
    DM_ADDR   = ADDR_W'({rf_ph, rf_pl});
    DM_WDATA  = rf_a;
    IO_RE     = 1'b0;
    IO_WE     = 1'b0;
    IO_ADDR   = ir_reg[5:0];
    IO_WDATA  = rf_a;
    squash    = 1'b0;
    redirect  = 1'b0;
    tbl_start = 1'b0;
    target    = pc_reg + ADDR_W'(1);
    if (state_reg == ST_TABLE) begin
      // (RULE6) table byte written back
      wb_en   = 1'b1;
      wb_addr = tbl_rd_reg;
      wb_data = tbl_hi_reg ? PM_DATA[15:8] : PM_DATA[7:0];
      squash  = 1'b1;
    end else begin
      unique case (ir_cls)
        rcd_pkg::CLS_ALU, rcd_pkg::CLS_IMM: begin
          // (RULE2) same cycle write back
          wb_en   = (alu_op != rcd_pkg::ALU_NOP) && (alu_op != rcd_pkg::ALU_CP);
          // (RULE8) flags follow the result
          sr_load = (alu_op != rcd_pkg::ALU_NOP) && (alu_op != rcd_pkg::ALU_MOV);
        end
        rcd_pkg::CLS_MEM: begin
          unique case (ir_msub)
            // (RULE5) pointer indirect access
            rcd_pkg::MEM_LD: begin
              DM_RE   = 1'b1;
              wb_en   = 1'b1;
              wb_data = DM_RDATA;
            end
            rcd_pkg::MEM_ST: DM_WE = 1'b1;
            // (RULE9) extended io via data space, address in next word
            rcd_pkg::MEM_LDD, rcd_pkg::MEM_STD: begin
              DM_ADDR = ADDR_W'(PM_DATA);
              DM_RE   = (ir_msub == rcd_pkg::MEM_LDD);
              DM_WE   = (ir_msub == rcd_pkg::MEM_STD);
              wb_en   = (ir_msub == rcd_pkg::MEM_LDD);
              wb_data = DM_RDATA;
              squash  = 1'b1;
            end
            rcd_pkg::MEM_IN: begin
              IO_RE   = (IO_ADDR != rcd_pkg::STATUS_IO);
              wb_en   = 1'b1;
              wb_data = (IO_ADDR == rcd_pkg::STATUS_IO) ? status_reg : IO_RDATA;
            end
            rcd_pkg::MEM_OUT: begin
              IO_WE   = (IO_ADDR != rcd_pkg::STATUS_IO);
              sr_load = (IO_ADDR == rcd_pkg::STATUS_IO);
              sr_next = rf_a;
            end
            rcd_pkg::MEM_TBL: begin
              tbl_start = 1'b1;
              squash    = 1'b1;
            end
            // (RULE9) bit forms reach the low io range only
            rcd_pkg::MEM_BIT: begin
              IO_ADDR = {1'b0, ir_reg[rcd_pkg::BADDR_LSB +: 5]};
              IO_RE   = 1'b1;
              unique case (ir_reg[rcd_pkg::BKIND_LSB +: 2])
                rcd_pkg::BIT_SKS: squash = |(IO_RDATA & bit_mask);
                rcd_pkg::BIT_SKC: squash = ~|(IO_RDATA & bit_mask);
                rcd_pkg::BIT_SET: begin
                  IO_WE    = 1'b1;
                  IO_WDATA = IO_RDATA | bit_mask;
                end
                rcd_pkg::BIT_CLR: begin
                  IO_WE    = 1'b1;
                  IO_WDATA = IO_RDATA & ~bit_mask;
                end
              endcase
            end
          endcase
        end
        rcd_pkg::CLS_BR: begin
          unique case (ir_iop)
            rcd_pkg::BR_JMP: begin
              redirect = 1'b1;
              target   = pc_reg + ADDR_W'({{(ADDR_W-12){ir_reg[11]}}, ir_reg[11:0]});
            end
            rcd_pkg::BR_SET, rcd_pkg::BR_CLR: begin
              redirect = status_reg[ir_reg[rcd_pkg::BFLAG_LSB +: 3]] == (ir_iop == rcd_pkg::BR_SET);
              target   = redirect ? pc_reg + ADDR_W'({{(ADDR_W-9){ir_reg[8]}}, ir_reg[8:0]}) : target;
            end
            rcd_pkg::BR_RSV: redirect = 1'b0;
          endcase
          squash = redirect;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // fetch and sequencing
  // --------------------------------------------------------------
  // (RULE4) program bus on its own
  assign PM_ADDR = pc_reg;

  // (RULE3) prefetch one word ahead
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg    <= ST_RUN;
      pc_reg       <= ADDR_W'(rcd_pkg::PC_RST);
      saved_pc_reg <= ADDR_W'(rcd_pkg::PC_RST);
    end else begin
      unique case (state_reg)
        // (RULE6) z word address to program memory
        ST_RUN: begin
          if (tbl_start) begin
            state_reg    <= ST_TABLE;
            saved_pc_reg <= pc_reg;
            pc_reg       <= z_word;
          end else begin
            pc_reg <= target;
          end
        end
        ST_TABLE: begin
          state_reg <= ST_RUN;
          pc_reg    <= saved_pc_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) ir_reg <= rcd_pkg::NOP_INSN;
    else ir_reg <= squash ? rcd_pkg::NOP_INSN : PM_DATA;
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tbl_rd_reg <= 5'h00;
      tbl_hi_reg <= 1'b0;
    end else if (tbl_start) begin
      tbl_rd_reg <= ir_rd;
      tbl_hi_reg <= rf_pl[0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) status_reg <= rcd_pkg::STATUS_RST;
    else if (sr_load) status_reg <= sr_next;
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic chk_live_reg;

  // checks start one edge after reset release, when the flops first leave reset
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) chk_live_reg <= 1'b0;
    else chk_live_reg <= 1'b1;
  end

  default clocking ck @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B || !chk_live_reg);

  sequence tbl_fetch_s;
    state_reg == ST_TABLE && PM_ADDR == $past(z_word);
  endsequence
  sequence tbl_return_s;
    state_reg == ST_RUN && PM_ADDR == $past(pc_reg, 2);
  endsequence

  rf_second_read_a: assert property ( // (RULE1)
    (wb_en && !squash && wb_addr == PM_DATA[4:0]) |=> rf_b == $past(wb_data)) else $error("second operand stale");
  alu_one_cycle_a: assert property ( // (RULE2)
    (state_reg == ST_RUN && ir_cls == rcd_pkg::CLS_ALU && alu_op == rcd_pkg::ALU_ADD)
      |-> wb_en && wb_addr == ir_rd && wb_data == 8'(rf_a + rf_b)) else $error("add not written back");
  fetch_step_a: assert property ( // (RULE3)
    (state_reg == ST_RUN && !redirect && !tbl_start) |=> pc_reg == $past(pc_reg) + ADDR_W'(1))
    else $error("fetch did not advance");
  data_no_stall_a: assert property ( // (RULE4)
    (DM_RE || DM_WE) |=> state_reg == ST_RUN && pc_reg == $past(pc_reg) + ADDR_W'(1))
    else $error("data access stalled fetch");
  ptr_addr_a: assert property ( // (RULE5)
    (state_reg == ST_RUN && ir_cls == rcd_pkg::CLS_MEM && ir_msub == rcd_pkg::MEM_ST)
      |-> DM_WE && !DM_RE && DM_ADDR == ADDR_W'({rf_ph, rf_pl})) else $error("pointer address wrong");
  tbl_read_a: assert property ( // (RULE6)
    tbl_start |=> tbl_fetch_s ##1 tbl_return_s) else $error("table read sequence wrong");
  imm_load_a: assert property ( // (RULE7)
    (state_reg == ST_RUN && ir_cls == rcd_pkg::CLS_IMM && ir_iop == rcd_pkg::IMM_LDI)
      |-> wb_en && wb_addr[4] && wb_data == ir_reg[7:0]) else $error("constant load wrong");
  flag_update_a: assert property ( // (RULE8)
    (state_reg == ST_RUN && (ir_cls == rcd_pkg::CLS_ALU || ir_cls == rcd_pkg::CLS_IMM) && alu_op == rcd_pkg::ALU_SUB)
      |=> status_reg[rcd_pkg::FLAG_Z] == ($past(alu_res) == 8'h00)
       && status_reg[rcd_pkg::FLAG_N] == ($past(alu_res) >= 8'h80)) else $error("flags not updated");
  direct_no_io_a: assert property ( // (RULE9)
    (state_reg == ST_RUN && ir_cls == rcd_pkg::CLS_MEM && (ir_msub == rcd_pkg::MEM_LDD || ir_msub == rcd_pkg::MEM_STD))
      |-> !IO_RE && !IO_WE && (DM_RE || DM_WE) ##1 ir_reg == rcd_pkg::NOP_INSN) else $error("direct access wrong");
  bit_io_range_a: assert property ( // (RULE9)
    (IO_RE && IO_WE) |-> IO_ADDR < 6'h20) else $error("bit access outside low io");
  bypass_rd_a: assert property ( // (RULE10)
    (wb_en && !squash && wb_addr == rcd_pkg::rd_of(PM_DATA)) |=> rf_a == $past(wb_data))
    else $error("result not forwarded");
  ptr_pair_a: assert property ( // (RULE11)
    (state_reg == ST_RUN && ir_cls == rcd_pkg::CLS_MEM && ir_msub == rcd_pkg::MEM_ST
      && ir_reg[rcd_pkg::PSEL_LSB +: 2] == rcd_pkg::PSEL_X)
      |-> DM_ADDR == {rcd_regfile_i.mem[rcd_pkg::PTR_X | 5'h01], rcd_regfile_i.mem[rcd_pkg::PTR_X]})
    else $error("pointer pair order wrong");
endmodule // rcd_core

// ===== rcd_regfile.sv
// package of constants and the working register file of the core datapath
`timescale 1ns/1ps

package rcd_pkg;
  localparam int DATA_W    = 8;
  localparam int NUM_REGS  = 32;
  localparam int REG_AW    = 5;
  localparam int INSN_W    = 16;
  localparam int ADDR_W    = 16;
  localparam int IO_AW     = 6;
  // --------------------------------------------------------------
  // instruction fields
  // --------------------------------------------------------------
  localparam int CLS_LSB   = 14;
  localparam int ROP_LSB   = 10;
  localparam int IOP_LSB   = 12;
  localparam int MSUB_LSB  = 11;
  localparam int RD_LSB    = 5;
  localparam int IRD_LSB   = 8;
  localparam int MRD_LSB   = 6;
  localparam int PSEL_LSB  = 4;
  localparam int BKIND_LSB = 9;
  localparam int BADDR_LSB = 4;
  localparam int BFLAG_LSB = 9;
  localparam logic [1:0] CLS_ALU = 2'h0;
  localparam logic [1:0] CLS_IMM = 2'h1;
  localparam logic [1:0] CLS_MEM = 2'h2;
  localparam logic [1:0] CLS_BR  = 2'h3;
  localparam logic [3:0] ALU_NOP = 4'h0;
  localparam logic [3:0] ALU_ADD = 4'h1;
  localparam logic [3:0] ALU_ADC = 4'h2;
  localparam logic [3:0] ALU_SUB = 4'h3;
  localparam logic [3:0] ALU_SBC = 4'h4;
  localparam logic [3:0] ALU_AND = 4'h5;
  localparam logic [3:0] ALU_OR  = 4'h6;
  localparam logic [3:0] ALU_EOR = 4'h7;
  localparam logic [3:0] ALU_MOV = 4'h8;
  localparam logic [3:0] ALU_CP  = 4'h9;
  localparam logic [3:0] ALU_COM = 4'ha;
  localparam logic [3:0] ALU_NEG = 4'hb;
  localparam logic [3:0] ALU_INC = 4'hc;
  localparam logic [3:0] ALU_DEC = 4'hd;
  localparam logic [3:0] ALU_LSR = 4'he;
  localparam logic [3:0] ALU_ROR = 4'hf;
  localparam logic [1:0] IMM_LDI = 2'h0;
  localparam logic [1:0] IMM_SUB = 2'h1;
  localparam logic [1:0] IMM_AND = 2'h2;
  localparam logic [1:0] IMM_OR  = 2'h3;
  localparam logic [2:0] MEM_LD  = 3'h0;
  localparam logic [2:0] MEM_ST  = 3'h1;
  localparam logic [2:0] MEM_LDD = 3'h2;
  localparam logic [2:0] MEM_STD = 3'h3;
  localparam logic [2:0] MEM_IN  = 3'h4;
  localparam logic [2:0] MEM_OUT = 3'h5;
  localparam logic [2:0] MEM_TBL = 3'h6;
  localparam logic [2:0] MEM_BIT = 3'h7;
  localparam logic [1:0] BIT_SKS = 2'h0;
  localparam logic [1:0] BIT_SKC = 2'h1;
  localparam logic [1:0] BIT_SET = 2'h2;
  localparam logic [1:0] BIT_CLR = 2'h3;
  localparam logic [1:0] BR_JMP  = 2'h0;
  localparam logic [1:0] BR_SET  = 2'h1;
  localparam logic [1:0] BR_CLR  = 2'h2;
  localparam logic [1:0] BR_RSV  = 2'h3;
  localparam logic [1:0] PSEL_X  = 2'h0;
  localparam logic [1:0] PSEL_Y  = 2'h1;
  localparam logic [4:0] PTR_X   = 5'h1a;
  localparam logic [4:0] PTR_Y   = 5'h1c;
  localparam logic [4:0] PTR_Z   = 5'h1e;
  // --------------------------------------------------------------
  // status bits and reset values
  // --------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [5:0]  STATUS_IO  = 6'h3f;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [15:0] NOP_INSN   = 16'h0000;

  function automatic logic [REG_AW-1:0] rd_of(input logic [INSN_W-1:0] insn);
    logic [1:0] cls;
    cls = insn[CLS_LSB +: 2];
    if (cls == CLS_IMM) rd_of = {1'b1, insn[IRD_LSB +: 4]};
    else if (cls == CLS_MEM) rd_of = insn[MRD_LSB +: REG_AW];
    else rd_of = insn[RD_LSB +: REG_AW];
  endfunction

  function automatic logic [REG_AW-1:0] ptr_of(input logic [INSN_W-1:0] insn);
    logic [1:0] sel;
    sel = insn[PSEL_LSB +: 2];
    if (insn[MSUB_LSB +: 3] == MEM_TBL) ptr_of = PTR_Z;
    else if (sel == PSEL_X) ptr_of = PTR_X;
    else if (sel == PSEL_Y) ptr_of = PTR_Y;
    else ptr_of = PTR_Z;
  endfunction
endpackage

module rcd_regfile #(
  parameter int DEPTH = rcd_pkg::NUM_REGS,
  parameter int AW    = rcd_pkg::REG_AW,
  parameter int DW    = rcd_pkg::DATA_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [AW-1:0] raddr_a,
  input  wire logic [AW-1:0] raddr_b,
  input  wire logic [AW-1:0] raddr_pl,
  input  wire logic [AW-1:0] raddr_ph,
  output logic      [DW-1:0] rdata_a,
  output logic      [DW-1:0] rdata_b,
  output logic      [DW-1:0] rdata_pl,
  output logic      [DW-1:0] rdata_ph,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata
);
  logic [DW-1:0] mem [DEPTH];

  // (RULE10) write-through, next read sees result
  function automatic logic [DW-1:0] rd_bypass(input logic [AW-1:0] ra, input logic [DW-1:0] stored);
    if (we && waddr == ra) return wdata;
    return stored;
  endfunction

  // (RULE1) single cycle write
  always_ff @(posedge clk) begin
    if (we) mem[waddr] <= wdata;
  end

  // (RULE1) registered read ports
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_a  <= '0;
      rdata_b  <= '0;
      rdata_pl <= '0;
      rdata_ph <= '0;
    end else begin
      rdata_a  <= rd_bypass(raddr_a, mem[raddr_a]);
      rdata_b  <= rd_bypass(raddr_b, mem[raddr_b]);
      rdata_pl <= rd_bypass(raddr_pl, mem[raddr_pl]);
      rdata_ph <= rd_bypass(raddr_ph, mem[raddr_ph]);
    end
  end
endmodule // rcd_regfile

// ===== rcd_mem_model.sv
// program, data and io memory model on the far side of the core
`timescale 1ns/1ps

module rcd_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] pm_addr,
  output logic      [15:0] pm_data,
  input  wire logic [15:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  input  wire logic        dm_re,
  output logic      [7:0]  dm_rdata,
  input  wire logic [5:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_we,
  input  wire logic        io_re,
  output logic      [7:0]  io_rdata
);
  logic [15:0] pm [0:255];
  logic [7:0]  dm [0:65535];
  logic [7:0]  io [0:63];
  logic [7:0]  dm_last;
  logic [7:0]  io_last;

  assign pm_data = pm[pm_addr[7:0]];
  // unselected read lines show the inverse of the last value
  assign dm_rdata = dm_re ? dm[dm_addr] : ~dm_last;
  assign io_rdata = io_re ? io[io_addr] : ~io_last;

  always @(posedge clk) begin
    if (dm_we) dm[dm_addr] <= dm_wdata;
    if (dm_re) dm_last <= dm[dm_addr];
    if (io_we) io[io_addr] <= io_wdata;
    if (io_re) io_last <= io[io_addr];
  end
endmodule // rcd_mem_model

// ===== risc_cpu_core_datapath_tb.sv
// self-checking testbench of the core datapath
`timescale 1ns/1ps

module risc_cpu_core_datapath_tb;
  logic        CLOCK;
  logic        RST_B;
  logic [15:0] PM_ADDR;
  logic [15:0] PM_DATA;
  logic [15:0] DM_ADDR;
  logic [7:0]  DM_WDATA;
  logic        DM_WE;
  logic        DM_RE;
  logic [7:0]  DM_RDATA;
  logic [5:0]  IO_ADDR;
  logic [7:0]  IO_WDATA;
  logic        IO_WE;
  logic        IO_RE;
  logic [7:0]  IO_RDATA;
  int          errors;
  int          n_tests;
  int          run_cycles;
  logic [15:0] prog [0:23];

  rcd_core rcd_core_i (.CLOCK(CLOCK), .RST_B(RST_B), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
    .DM_ADDR(DM_ADDR), .DM_WDATA(DM_WDATA), .DM_WE(DM_WE), .DM_RE(DM_RE), .DM_RDATA(DM_RDATA),
    .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WE(IO_WE), .IO_RE(IO_RE), .IO_RDATA(IO_RDATA));

  rcd_mem_model rcd_mem_model_i (.clk(CLOCK), .pm_addr(PM_ADDR), .pm_data(PM_DATA),
    .dm_addr(DM_ADDR), .dm_wdata(DM_WDATA), .dm_we(DM_WE), .dm_re(DM_RE), .dm_rdata(DM_RDATA),
    .io_addr(IO_ADDR), .io_wdata(IO_WDATA), .io_we(IO_WE), .io_re(IO_RE), .io_rdata(IO_RDATA));

  // ------------------------------------------------------------
  // clock and checking
  // ------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // reset for 20 cycles, load prog, run until the fetch reaches stop
  task automatic run_prog(input logic [15:0] stop);
    RST_B <= 1'b0;
    @(posedge CLOCK);
    for (int i = 0; i < 256; i++) rcd_mem_model_i.pm[i] = (i < 24) ? prog[i] : 16'hc3e7;
    for (int i = 0; i < 64; i++) rcd_mem_model_i.io[i] = 8'h00;
    rcd_mem_model_i.dm_last = 8'h00;
    rcd_mem_model_i.io_last = 8'h00;
    repeat (19) @(posedge CLOCK);
    check(PM_ADDR, 16'h0000);
    RST_B <= 1'b1;
    run_cycles = 0;
    while (PM_ADDR !== stop) begin
      @(posedge CLOCK);
      #1;
      run_cycles++;
      if (run_cycles > 200) begin
        errors++;
        results();
      end
    end
    repeat (4) @(posedge CLOCK);
  endtask

  // alu chain, status read, pointer store, direct load, table read, bit set
  task automatic scen_alu_table;
    prog = '{16'h4005, 16'h4103, 16'h0611, 16'hac01, 16'h5008, 16'ha4bf, 16'hac82, 16'h4a34,
             16'h4b12, 16'h44a5, 16'h8d00, 16'h9540, 16'h1234, 16'had43, 16'h4e41, 16'h4f00,
             16'hb580, 16'had84, 16'hbc53, 16'hcfff, 16'hc3e7, 16'hc3e7, 16'hc3e7, 16'hc3e7};
    run_prog(16'h0013);
    check({8'h00, rcd_mem_model_i.io[1]}, 16'h0008);
    check({8'h00, rcd_mem_model_i.io[2]}, 16'h0002);
    check({8'h00, rcd_mem_model_i.dm[16'h1234]}, 16'h00a5);
    check({8'h00, rcd_mem_model_i.io[3]}, 16'h00a5);
    check({8'h00, rcd_mem_model_i.io[4]}, 16'h00c3);
    check({8'h00, rcd_mem_model_i.io[5]}, 16'h0008);
    // one word per cycle, two extra for the table read
    check(16'(run_cycles), 16'h0015);
    check({8'h00, rcd_mem_model_i.io[0]}, 16'h0000);
  endtask

  // second reset mid-run: logic ops, both skips, load through y, taken branch
  task automatic scen_skip_branch;
    prog = '{16'h40f0, 16'h413c, 16'h1e11, 16'hac01, 16'h2a00, 16'h0a11, 16'hac02, 16'hb824,
             16'hac03, 16'hba23, 16'hac03, 16'h4c05, 16'h4d00, 16'h8490, 16'h3a40, 16'hd001,
             16'hac83, 16'hac84, 16'ha4ff, 16'hacc5, 16'hcfff, 16'hc3e7, 16'hc3e7, 16'hc3e7};
    rcd_mem_model_i.dm[16'h0005] = 8'h81;
    run_prog(16'h0014);
    check({8'h00, rcd_mem_model_i.io[1]}, 16'h00cc);
    check({8'h00, rcd_mem_model_i.io[2]}, 16'h0070);
    // skipped and branched-over words must not write
    check({8'h00, rcd_mem_model_i.io[3]}, 16'h0000);
    check({8'h00, rcd_mem_model_i.io[4]}, 16'h0040);
    check({8'h00, rcd_mem_model_i.io[5]}, 16'h0039);
    check(16'(run_cycles), 16'h0014);
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    RST_B = 1'b0;
    scen_alu_table();
    scen_skip_branch();
    results();
  end
endmodule // risc_cpu_core_datapath_tb
